// file: common/cct_pkg.sv
`default_nettype none
package cct_pkg;
  // ==========================================================================
  // register map (byte addresses on the APB bus)
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_OUT_CTL = 8'h08;
  localparam logic [7:0] ADDR_CAP_EDGE = 8'h0C;
  localparam logic [7:0] ADDR_EVT_EDGE = 8'h10;
  localparam logic [7:0] ADDR_OPTION = 8'h14;
  localparam logic [7:0] ADDR_CCR0 = 8'h18;
  localparam logic [7:0] ADDR_CCR1 = 8'h1C;
  localparam logic [7:0] ADDR_CCR2 = 8'h20;
  localparam logic [7:0] ADDR_CCR3 = 8'h24;
  localparam logic [7:0] ADDR_CNT = 8'h28;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h30;
  localparam logic [7:0] ADDR_CC_FUNC = 8'h34;
  localparam logic [7:0] REG_STRIDE = 8'h04;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int CTRL0_RUN_BIT = 7;
  localparam int CTRL1_SW_TRIG_BIT = 6;
  localparam int CTRL1_EXT_EVT_BIT = 5;
  localparam int OPT_OVF_BIT = 0;
  localparam int IRQ_OVF_BIT = 4;
  localparam int NUM_CH = 4;
  localparam int PRESC_W = 7;

  // ==========================================================================
  // values
  // ==========================================================================
  localparam logic [15:0] CNT_STOPPED = 16'hFFFF;
  localparam logic [15:0] CNT_READ_STOPPED = 16'h0000;
  localparam logic [15:0] CNT_WRAP = 16'h0000;
  localparam logic [15:0] CCR_RESET = 16'h0000;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  localparam logic [PRESC_W-1:0] PRESC_STEP = 7'h01;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 7'h00;

  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [2:0] MODE_EXT_EVENT = 3'h1;
  localparam logic [2:0] MODE_EXT_TRIG = 3'h2;
  localparam logic [2:0] MODE_ONE_SHOT = 3'h3;
  localparam logic [2:0] MODE_PWM = 3'h4;
  localparam logic [2:0] MODE_FREE_RUN = 3'h5;
  localparam logic [2:0] MODE_PULSE_MEAS = 3'h6;
  localparam logic [2:0] MODE_PROHIBITED = 3'h7;

  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef struct packed {
    logic run_enable;
    logic [2:0] clk_div_sel;
  } cct_ctrl_t;

  typedef struct packed {
    logic ext_event_enable;
    logic [2:0] timer_mode;
  } cct_mode_t;

  typedef enum logic [2:0] {
    ST_STOP = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } cct_state_t;

  // internal count clock tick: prescaler low bits all ones selects fxx/2^sel
  function automatic logic div_tick(input logic [PRESC_W-1:0] presc, input logic [2:0] sel);
    logic [PRESC_W-1:0] mask;
    mask = PRESC_W'((8'h01 << sel) - 8'h01);
    return (presc & mask) == mask;
  endfunction : div_tick
endpackage : cct_pkg
`default_nettype wire

// file: verilog/cct_edge_det.sv
`timescale 1ns/10ps
`default_nettype none
module cct_edge_det (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  output logic edge_pulse
);
  logic prev_r;
  logic rise;
  logic fall;

  // prev follows the pin even while disabled so enabling makes no false edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= pin;
    end
  end

  assign rise = pin & ~prev_r;
  assign fall = ~pin & prev_r;

  always_comb begin
    unique case (edge_sel)
      cct_pkg::EDGE_NONE: edge_pulse = 1'b0;
      cct_pkg::EDGE_RISE: edge_pulse = enable & rise;
      cct_pkg::EDGE_FALL: edge_pulse = enable & fall;
      cct_pkg::EDGE_BOTH: edge_pulse = enable & (rise | fall);
    endcase
  end
endmodule : cct_edge_det
`default_nettype wire

// file: verilog/cct_timer.sv
`timescale 1ns/10ps
`default_nettype none
module cct_timer (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] TIMER_INPUT,
  output logic [3:0] TIMER_OUTPUT,
  output logic [3:0] CH_MATCH_CAPTURE_IRQ,
  output logic COUNTER_OVERFLOW_IRQ,
  output logic IRQ
);
  localparam int NCH = cct_pkg::NUM_CH;

  // ==========================================================================
  // registers
  // ==========================================================================
  cct_pkg::cct_ctrl_t ctrl_r;
  cct_pkg::cct_mode_t mode_r;
  cct_pkg::cct_state_t state_r;
  cct_pkg::cct_state_t state_nxt;
  logic [7:0] output_control_reg_r;
  logic [7:0] capture_edge_select_reg_r;
  logic [3:0] event_edge_select_reg_r;
  logic [NCH-1:0] cc_capture_r;
  logic overflow_flag_r;
  logic [15:0] capcomp_reg_r [NCH];
  logic [15:0] cmp_buf_r [NCH];
  logic [4:0] irq_status_r;
  logic [4:0] irq_mask_r;
  logic [15:0] cnt_r;
  logic started_r;
  logic step_r;
  logic [cct_pkg::PRESC_W-1:0] presc_r;
  logic [NCH-1:0] wave_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [NCH-1:0] ch_irq_r;
  logic ovf_irq_r;
  logic irq_r;
  logic [NCH-1:0] tout_r;

  // ==========================================================================
  // bus decode
  // ==========================================================================
  logic wr_en;
  logic rd_take;
  logic [31:0] rd_data;
  logic rd_hit;
  logic run;
  logic sw_trig;

  assign wr_en = PSEL & PENABLE & pready_r & PWRITE;
  assign rd_take = PSEL & PENABLE & ~pready_r;
  assign run = ctrl_r.run_enable;

  function automatic logic wr_to(input logic [7:0] addr, input logic en, input logic [7:0] target);
    return en && (addr == target);
  endfunction : wr_to

  // ==========================================================================
  // edge detectors and count clock
  // ==========================================================================
  logic [NCH-1:0] cap_edge;
  logic evt_edge;
  logic trig_edge;
  logic int_tick;
  logic use_ext;
  logic tick;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_cap
      cct_edge_det u_cap (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .enable(run),
        .pin(TIMER_INPUT[g]),
        .edge_sel(capture_edge_select_reg_r[2*g+1:2*g]),
        .edge_pulse(cap_edge[g])
      );
    end
  endgenerate

  // input 0 also feeds the event counter and the start trigger
  cct_edge_det u_evt (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .enable(run),
    .pin(TIMER_INPUT[0]),
    .edge_sel(event_edge_select_reg_r[1:0]),
    .edge_pulse(evt_edge)
  );

  cct_edge_det u_trig (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .enable(run),
    .pin(TIMER_INPUT[0]),
    .edge_sel(event_edge_select_reg_r[3:2]),
    .edge_pulse(trig_edge)
  );

  assign int_tick = cct_pkg::div_tick(presc_r, ctrl_r.clk_div_sel);
  assign use_ext = mode_r.ext_event_enable | (mode_r.timer_mode == cct_pkg::MODE_EXT_EVENT);
  assign tick = (state_r == cct_pkg::ST_RUN) & (use_ext ? evt_edge : int_tick);

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      presc_r <= cct_pkg::PRESC_RESET;
    end else if (!run) begin
      presc_r <= cct_pkg::PRESC_RESET;
    end else begin
      presc_r <= presc_r + cct_pkg::PRESC_STEP;
    end
  end

  // ==========================================================================
  // mode decode and sequencing
  // ==========================================================================
  logic trig_mode;
  logic pwm_like;
  logic clear_on_ccr0;
  logic pulse_meas;
  logic trigger;
  logic [NCH-1:0] capture_fn;
  logic [NCH-1:0] match_ev;
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] ch_ev;
  logic ccr0_clear;
  logic ovf_ev;

  always_comb begin
    trig_mode = 1'b0;
    pwm_like = 1'b0;
    clear_on_ccr0 = 1'b0;
    pulse_meas = 1'b0;
    unique case (mode_r.timer_mode)
      cct_pkg::MODE_INTERVAL: clear_on_ccr0 = 1'b1;
      cct_pkg::MODE_EXT_EVENT: clear_on_ccr0 = 1'b1;
      cct_pkg::MODE_EXT_TRIG,
      cct_pkg::MODE_ONE_SHOT: begin
        trig_mode = 1'b1;
        pwm_like = 1'b1;
        clear_on_ccr0 = 1'b1;
      end
      cct_pkg::MODE_PWM: begin
        pwm_like = 1'b1;
        clear_on_ccr0 = 1'b1;
      end
      cct_pkg::MODE_FREE_RUN: clear_on_ccr0 = 1'b0;
      cct_pkg::MODE_PULSE_MEAS: pulse_meas = 1'b1;
      cct_pkg::MODE_PROHIBITED: clear_on_ccr0 = 1'b0;
    endcase
  end

  assign sw_trig = wr_to(PADDR, wr_en, cct_pkg::ADDR_CTRL1) & PWDATA[cct_pkg::CTRL1_SW_TRIG_BIT] & trig_mode;
  assign trigger = run & trig_mode & (sw_trig | trig_edge);
  assign capture_fn = cc_capture_r | {NCH{pulse_meas}};

  always_comb begin
    for (int m = 0; m < NCH; m++) begin
      match_ev[m] = step_r & ~capture_fn[m] & (cnt_r == cmp_buf_r[m]);
      cap_ev[m] = cap_edge[m] & capture_fn[m] & (state_r == cct_pkg::ST_RUN);
    end
  end

  assign ch_ev = match_ev | cap_ev;
  assign ccr0_clear = clear_on_ccr0 & ~capture_fn[0] & (cnt_r == cmp_buf_r[0]);
  assign ovf_ev = tick & started_r & ~ccr0_clear & (cnt_r == cct_pkg::CNT_STOPPED);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cct_pkg::ST_STOP: begin
        if (run && mode_r.timer_mode != cct_pkg::MODE_PROHIBITED) begin
          state_nxt = trig_mode ? cct_pkg::ST_WAIT : cct_pkg::ST_RUN;
        end
      end
      cct_pkg::ST_WAIT: begin
        if (!run) begin
          state_nxt = cct_pkg::ST_STOP;
        end else if (trigger) begin
          state_nxt = cct_pkg::ST_RUN;
        end
      end
      cct_pkg::ST_RUN: begin
        if (!run) begin
          state_nxt = cct_pkg::ST_STOP;
        end else if (mode_r.timer_mode == cct_pkg::MODE_ONE_SHOT && match_ev[0]) begin
          state_nxt = cct_pkg::ST_WAIT;
        end
      end
      default: state_nxt = cct_pkg::ST_STOP;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_r <= cct_pkg::ST_STOP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // 16-bit counter
  // ==========================================================================
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cnt_r <= cct_pkg::CNT_STOPPED;
      started_r <= 1'b0;
      step_r <= 1'b0;
    end else if (state_nxt != cct_pkg::ST_RUN || (trigger && state_r == cct_pkg::ST_RUN)) begin
      cnt_r <= cct_pkg::CNT_STOPPED;
      started_r <= 1'b0;
      step_r <= 1'b0;
    end else if (pulse_meas && cap_ev != '0) begin
      cnt_r <= cct_pkg::CNT_WRAP;
      step_r <= 1'b0;
    end else if (tick) begin
      started_r <= 1'b1;
      step_r <= 1'b1;
      if (!started_r || ccr0_clear || ovf_ev) begin
        cnt_r <= cct_pkg::CNT_WRAP;
      end else begin
        cnt_r <= cnt_r + cct_pkg::CNT_STEP;
      end
    end else begin
      step_r <= 1'b0;
    end
  end

  // ==========================================================================
  // control registers
  // ==========================================================================
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_r <= '0;
      mode_r <= '0;
      output_control_reg_r <= 8'h00;
      capture_edge_select_reg_r <= 8'h00;
      event_edge_select_reg_r <= 4'h0;
      cc_capture_r <= '0;
      irq_mask_r <= 5'h00;
    end else begin
      if (wr_to(PADDR, wr_en, cct_pkg::ADDR_CTRL0)) begin
        ctrl_r <= {PWDATA[cct_pkg::CTRL0_RUN_BIT], PWDATA[2:0]};
      end
      if (wr_to(PADDR, wr_en, cct_pkg::ADDR_CTRL1)) begin
        mode_r <= {PWDATA[cct_pkg::CTRL1_EXT_EVT_BIT], PWDATA[2:0]};
      end
      if (wr_to(PADDR, wr_en, cct_pkg::ADDR_OUT_CTL)) begin
        output_control_reg_r <= PWDATA[7:0];
      end
      if (wr_to(PADDR, wr_en, cct_pkg::ADDR_CAP_EDGE)) begin
        capture_edge_select_reg_r <= PWDATA[7:0];
      end
      if (wr_to(PADDR, wr_en, cct_pkg::ADDR_EVT_EDGE)) begin
        event_edge_select_reg_r <= PWDATA[3:0];
      end
      if (wr_to(PADDR, wr_en, cct_pkg::ADDR_CC_FUNC)) begin
        cc_capture_r <= PWDATA[NCH-1:0];
      end
      if (wr_to(PADDR, wr_en, cct_pkg::ADDR_IRQ_MASK)) begin
        irq_mask_r <= PWDATA[4:0];
      end
    end
  end

  // capture/compare registers and their hidden compare buffers
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int m = 0; m < NCH; m++) begin
        capcomp_reg_r[m] <= cct_pkg::CCR_RESET;
        cmp_buf_r[m] <= cct_pkg::CCR_RESET;
      end
    end else begin
      for (int m = 0; m < NCH; m++) begin
        if (cap_ev[m]) begin
          capcomp_reg_r[m] <= cnt_r;
        end else if (wr_to(PADDR, wr_en, cct_pkg::ADDR_CCR0 + 8'(m) * cct_pkg::REG_STRIDE)) begin
          capcomp_reg_r[m] <= PWDATA[15:0];
          if (!capture_fn[m]) begin
            cmp_buf_r[m] <= PWDATA[15:0];
          end
        end
      end
    end
  end

  // overflow flag: set wins over a software clear, stop clears it
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      overflow_flag_r <= 1'b0;
    end else if (!run) begin
      overflow_flag_r <= 1'b0;
    end else if (ovf_ev) begin
      overflow_flag_r <= 1'b1;
    end else if (wr_to(PADDR, wr_en, cct_pkg::ADDR_OPTION) && !PWDATA[cct_pkg::OPT_OVF_BIT]) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // ==========================================================================
  // interrupts
  // ==========================================================================
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_status_r <= 5'h00;
    end else begin
      irq_status_r <= (irq_status_r & ~(wr_to(PADDR, wr_en, cct_pkg::ADDR_IRQ_STATUS) ? PWDATA[4:0] : 5'h00))
                      | {ovf_ev, ch_ev};
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ch_irq_r <= '0;
      ovf_irq_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ch_irq_r <= ch_ev;
      ovf_irq_r <= ovf_ev;
      irq_r <= |(irq_status_r & irq_mask_r);
    end
  end

  // ==========================================================================
  // output controller
  // ==========================================================================
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wave_r <= '0;
    end else if (state_r != cct_pkg::ST_RUN) begin
      wave_r <= '0;
    end else begin
      for (int m = 0; m < NCH; m++) begin
        if (pwm_like && m != 0) begin
          if (match_ev[m]) begin
            wave_r[m] <= 1'b1;
          end else if (match_ev[0]) begin
            wave_r[m] <= 1'b0;
          end
        end else if (match_ev[m]) begin
          wave_r[m] <= ~wave_r[m];
        end
      end
    end
  end

  // low nibble enables the wave, high nibble sets the idle level
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tout_r <= '0;
    end else begin
      tout_r <= output_control_reg_r[7:4] ^ (output_control_reg_r[3:0] & wave_r & {NCH{run}});
    end
  end

  // ==========================================================================
  // APB read side, one wait state
  // ==========================================================================
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (PADDR)
      cct_pkg::ADDR_CTRL0: rd_data = {24'h00_0000, ctrl_r.run_enable, 4'h0, ctrl_r.clk_div_sel};
      cct_pkg::ADDR_CTRL1: rd_data = {26'h000_0000, mode_r.ext_event_enable, 2'h0, mode_r.timer_mode};
      cct_pkg::ADDR_OUT_CTL: rd_data = {24'h00_0000, output_control_reg_r};
      cct_pkg::ADDR_CAP_EDGE: rd_data = {24'h00_0000, capture_edge_select_reg_r};
      cct_pkg::ADDR_EVT_EDGE: rd_data = {28'h000_0000, event_edge_select_reg_r};
      cct_pkg::ADDR_OPTION: rd_data = {31'h0000_0000, overflow_flag_r};
      cct_pkg::ADDR_CCR0: rd_data = {16'h0000, capcomp_reg_r[0]};
      cct_pkg::ADDR_CCR1: rd_data = {16'h0000, capcomp_reg_r[1]};
      cct_pkg::ADDR_CCR2: rd_data = {16'h0000, capcomp_reg_r[2]};
      cct_pkg::ADDR_CCR3: rd_data = {16'h0000, capcomp_reg_r[3]};
      cct_pkg::ADDR_CNT: rd_data = {16'h0000, run ? cnt_r : cct_pkg::CNT_READ_STOPPED};
      cct_pkg::ADDR_IRQ_STATUS: rd_data = {27'h000_0000, irq_status_r};
      cct_pkg::ADDR_IRQ_MASK: rd_data = {27'h000_0000, irq_mask_r};
      cct_pkg::ADDR_CC_FUNC: rd_data = {28'h000_0000, cc_capture_r};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= rd_take;
      pslverr_r <= rd_take & ~rd_hit;
      if (rd_take && !PWRITE) begin
        prdata_r <= rd_hit ? rd_data : 32'h0000_0000;
      end
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign TIMER_OUTPUT = tout_r;
  assign CH_MATCH_CAPTURE_IRQ = ch_irq_r;
  assign COUNTER_OVERFLOW_IRQ = ovf_irq_r;
  assign IRQ = irq_r;
endmodule : cct_timer
`default_nettype wire

// file: verification/cct_pin_src.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// pin source: presents requested levels after a chosen lag
module cct_pin_src (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] lvl_req,
  input wire logic [3:0] lag,
  output logic [3:0] pins
);
  logic [3:0] hist_r [16];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) hist_r[i] <= 4'h0;
    end else begin
      hist_r[0] <= lvl_req;
      for (int i = 1; i < 16; i++) hist_r[i] <= hist_r[i-1];
    end
  end
  assign pins = hist_r[lag];
endmodule : cct_pin_src
`default_nettype wire

// file: verification/cct_timer_chk.sv
`timescale 1ns/10ps
`default_nettype none
module cct_timer_chk (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [3:0] CH_MATCH_CAPTURE_IRQ,
  input wire logic COUNTER_OVERFLOW_IRQ,
  input wire logic IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // ====
  // bus
  apb_one_wait_a: assert property ($rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
    else $error("ready not in second access cycle");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
  ready_access_a: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
  err_decode_a: assert property (PREADY |-> PSLVERR == (PADDR > cct_pkg::ADDR_CC_FUNC || PADDR[1:0] != 2'h0))
    else $error("slave error does not follow address map");
  rdata_hold_a: assert property (!(PREADY && !PWRITE) |-> $stable(PRDATA)) else $error("read data moved");
  // ====
  // events
  ovf_pulse_a: assert property (COUNTER_OVERFLOW_IRQ |=> !COUNTER_OVERFLOW_IRQ)
    else $error("overflow pulse too long");
  ch_pulse_a: assert property (|CH_MATCH_CAPTURE_IRQ |=> (CH_MATCH_CAPTURE_IRQ & $past(CH_MATCH_CAPTURE_IRQ)) == 4'h0)
    else $error("channel pulse too long");
  irq_cause_a: assert property ($rose(IRQ) |-> $past(|CH_MATCH_CAPTURE_IRQ || COUNTER_OVERFLOW_IRQ) || $past(PREADY && PWRITE, 2))
    else $error("interrupt rose without cause");
  cover property (PSLVERR);
  cover property (COUNTER_OVERFLOW_IRQ);
  cover property ($rose(IRQ));
endmodule : cct_timer_chk
bind cct_timer cct_timer_chk chk (.CORE_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY,
  .PSLVERR, .CH_MATCH_CAPTURE_IRQ, .COUNTER_OVERFLOW_IRQ, .IRQ);
`default_nettype wire

// file: verification/cct_tb.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic CORE_CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, COUNTER_OVERFLOW_IRQ, IRQ, err;
  logic [7:0] PADDR;
  logic [4:0] seen;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [3:0] TIMER_INPUT, TIMER_OUTPUT, CH_MATCH_CAPTURE_IRQ, lvl_req, lag;
  int bad_count, check_count, seed, n, ccr_m[4], hits[4], base[4];
  cct_timer dut (.CORE_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .TIMER_INPUT, .TIMER_OUTPUT, .CH_MATCH_CAPTURE_IRQ, .COUNTER_OVERFLOW_IRQ, .IRQ);
  cct_pin_src src (.clk(CORE_CLK), .rst(SYS_RST), .lvl_req, .lag, .pins(TIMER_INPUT));
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) begin
    for (int m = 0; m < 4; m++) begin
      if (CH_MATCH_CAPTURE_IRQ[m] === 1'b1) hits[m]++;
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  // ====
  // bus master: hold request until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CORE_CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (k >= 50) begin
      bad_count++;
      tally_and_finish;
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd);
    cmp(what, exp, rd);
  endtask : rdc
  task automatic wait_pulse(input logic [4:0] sel, output int cyc);
    cyc = 0;
    do begin
      @(posedge CORE_CLK);
      cyc++;
    end while (({COUNTER_OVERFLOW_IRQ, CH_MATCH_CAPTURE_IRQ} & sel) === 5'h0 && cyc < 70000);
    seen = {COUNTER_OVERFLOW_IRQ, CH_MATCH_CAPTURE_IRQ};
    if (cyc >= 70000) begin
      bad_count++;
      tally_and_finish;
    end
  endtask : wait_pulse
  task automatic drive_pins(input logic [3:0] v);
    lvl_req <= v;
    lag <= 4'($random(seed) & 3);
    repeat (8) @(posedge CORE_CLK);
  endtask : drive_pins
  // ====
  // main sequence
  initial begin
    seed = 63;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, lvl_req, lag} = '0;
    SYS_RST = 1'b1;
    repeat (5) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    rdc("cnt stopped", cct_pkg::ADDR_CNT, 32'h0);
    apb(1'b0, 8'h38, 32'h0, rd);
    cmp("unmapped err", 32'h1, 32'(err));
    cmp("unmapped data", 32'h0, rd);
    for (int i = 0; i < 4; i++) begin
      rdc("ccr reset", cct_pkg::ADDR_CCR0 + 8'(4 * i), 32'h0);
      ccr_m[i] = $random(seed) & 16'hFFFF;
      wr(cct_pkg::ADDR_CCR0 + 8'(4 * i), 32'(ccr_m[i]));
      rdc("ccr rw", cct_pkg::ADDR_CCR0 + 8'(4 * i), 32'(ccr_m[i]));
    end
    wr(cct_pkg::ADDR_CTRL1, 32'h5);
    wr(cct_pkg::ADDR_CCR1, 32'hA);
    wr(cct_pkg::ADDR_CCR2, 32'h1E);
    for (int s = 0; s < 8; s++) begin
      wr(cct_pkg::ADDR_CTRL0, 32'h80 | 32'(s));
      wait_pulse(5'h02, n);
      wait_pulse(5'h04, n);
      cmp("match gap", 32'(20 << s), 32'(n));
      wr(cct_pkg::ADDR_CTRL0, 32'h0);
    end
    wr(cct_pkg::ADDR_CCR3, 32'hFFFF);
    wr(cct_pkg::ADDR_IRQ_MASK, 32'h10);
    wr(cct_pkg::ADDR_CTRL0, 32'h80);
    wait_pulse(5'h18, n);
    cmp("ovf with ffff match", 32'h18, 32'(seen & 5'h18));
    wait_pulse(5'h02, n);
    cmp("wrap gap", 32'hB, 32'(n));
    cmp("irq raised", 32'h1, 32'(IRQ));
    rdc("ovf flag", cct_pkg::ADDR_OPTION, 32'h1);
    rdc("status", cct_pkg::ADDR_IRQ_STATUS, 32'h1F);
    wr(cct_pkg::ADDR_IRQ_STATUS, 32'h10);
    apb(1'b0, cct_pkg::ADDR_IRQ_STATUS, 32'h0, rd);
    cmp("ovf cleared", 32'h0, rd & 32'h10);
    cmp("irq masked", 32'h0, 32'(IRQ));
    wr(cct_pkg::ADDR_CTRL0, 32'h0);
    rdc("flag on stop", cct_pkg::ADDR_OPTION, 32'h0);
    rdc("cnt on stop", cct_pkg::ADDR_CNT, 32'h0);
    wr(cct_pkg::ADDR_OUT_CTL, 32'hA0);
    repeat (2) @(posedge CORE_CLK);
    cmp("out level", 32'hA, 32'(TIMER_OUTPUT));
    wr(cct_pkg::ADDR_CTRL1, 32'h1);
    wr(cct_pkg::ADDR_EVT_EDGE, 32'h1);
    wr(cct_pkg::ADDR_CCR0, 32'h64);
    wr(cct_pkg::ADDR_CTRL0, 32'h80);
    repeat (6) begin
      drive_pins(4'h1);
      drive_pins(4'h0);
    end
    rdc("event count", cct_pkg::ADDR_CNT, 32'h5);
    wr(cct_pkg::ADDR_CTRL0, 32'h0);
    wr(cct_pkg::ADDR_CTRL1, 32'h0);
    wr(cct_pkg::ADDR_CCR0, 32'h4);
    wr(cct_pkg::ADDR_CTRL0, 32'h80);
    wait_pulse(5'h01, n);
    wait_pulse(5'h01, n);
    cmp("interval period", 32'h5, 32'(n));
    wr(cct_pkg::ADDR_CTRL0, 32'h0);
    wr(cct_pkg::ADDR_CC_FUNC, 32'hF);
    wr(cct_pkg::ADDR_CTRL1, 32'h5);
    wr(cct_pkg::ADDR_CTRL0, 32'h80);
    for (int e = 0; e < 4; e++) begin
      wr(cct_pkg::ADDR_CAP_EDGE, 32'(e * 85));
      base = hits;
      drive_pins(4'hF);
      drive_pins(4'h0);
      for (int m = 0; m < 4; m++) begin
        cmp("captures", 32'(e[0]) + 32'(e[1]), 32'(hits[m] - base[m]));
      end
    end
    tally_and_finish;
  end
endmodule : testbench
`default_nettype wire
